/* eeprom_map.vh */
// Register map, field positions, reset values and timing counts
// Assumes an 8-bit register port clocked at 125 MHz
`ifndef EEPROM_MAP_VH
`define EEPROM_MAP_VH
// ********************
// Register offsets
// ********************
`define EE_CTRL_ADDR     8'h1C
`define EE_DATA_ADDR     8'h1D
`define EE_ADDR_ADDR     8'h1E
`define EE_IRQ_STAT_ADDR 8'h1F
`define EE_IRQ_MASK_ADDR 8'h20
// ********************
// Control fields
// ********************
`define EE_READ_BIT      0
`define EE_LOAD_BIT      1
`define EE_UNLOCK_BIT    2
`define EE_BUSY_BIT      3
`define EE_CTRL_RST      8'h00
`define EE_DATA_RST      8'h00
`define EE_ADDR_RST      8'h00
// ********************
// Interrupt fields
// ********************
`define EE_IRQ_WDONE_BIT 0
`define EE_IRQ_RDONE_BIT 1
`define EE_IRQ_DROP_BIT  2
// ********************
// Timing
// ********************
`define EE_CLK_MHZ       125
`define EE_PROG_TIME_US  4000
`define EE_PROG_CYCLES   (`EE_PROG_TIME_US * `EE_CLK_MHZ)
`define EE_LAUNCH_CYCLES 4
`endif

/* eeprom_array.v */
// Storage array of 128 bytes with an eight-byte page buffer
// Assumes page writes are issued only when the controller is idle
`timescale 1ns/1ps
module eeprom_array (
  input  wire       sys_clk_in,
  input  wire       rst_in,
  input  wire       buf_clear_in,
  input  wire       buf_load_in,
  input  wire [2:0] buf_index_in,
  input  wire [7:0] buf_data_in,
  input  wire       commit_in,
  input  wire [3:0] commit_row_in,
  input  wire [6:0] rd_addr_in,
  output reg  [7:0] rd_data_out
);
  reg [7:0] mem [0:127];
  reg [7:0] page_buf [0:7];
  reg [7:0] page_valid_reg;
  integer   k;

  // ********************
  // Page buffer, one entry per byte slot
  // ********************
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_slot
      always @(posedge sys_clk_in) begin
        if (rst_in || buf_clear_in) begin
          page_valid_reg[i] <= 1'b0;
        end else if (buf_load_in && buf_index_in == i) begin
          page_buf[i]       <= buf_data_in;
          page_valid_reg[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // Commit of loaded slots only; one process owns the array
  always @(posedge sys_clk_in) begin
    for (k = 0; k < 8; k = k + 1) begin
      if (commit_in && page_valid_reg[k]) begin
        mem[{commit_row_in, k[2:0]}] <= page_buf[k];
      end
    end
  end

  // Registered read port
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule // eeprom_array

/* eeprom_page_ctrl.v */
// Data EEPROM page access controller with register port
// Assumes a one-cycle strobe master and a single 125 MHz clock
//
// How it works
// RQ1 - Software writes zero to control bits 7:4
// RQ2 - Busy flag bit 3, read-only, high while programming
// RQ3 - Software unlocks before writes, relocks after
// RQ4 - Unlock stays set until load falls
// RQ5 - Row select frozen while load set
// RQ6 - Data writes with load fill page buffer
// RQ7 - Each byte slot loaded once per page
// RQ8 - Load falling starts programming, busy follows
// RQ9 - No new access while busy
// RQ10 - Programming lasts about four milliseconds
// RQ11 - Avoid programming while transmitter enabled
// RQ12 - Read bit fetches byte, clears itself
// RQ13 - Data register holds written or fetched byte
// RQ14 - Address bits 6:3 row, 2:0 byte
// RQ15 - Load falling while locked discards buffer
// RQ16 - Programming timed by parameter clock counter
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "eeprom_map.vh"
module eeprom_page_ctrl #(
  parameter [31:0] PROG_CYCLES = `EE_PROG_CYCLES
) (
  input  wire       sys_clk_in,
  input  wire       rst_in,
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  output wire       irq_out
);
  // ********************
  // State encoding
  // ********************
  localparam [1:0] ST_IDLE   = 2'd0;
  localparam [1:0] ST_LAUNCH = 2'd1;
  localparam [1:0] ST_PROG   = 2'd2;
  localparam [1:0] ST_FETCH  = 2'd3;
  localparam [31:0] LAUNCH_CYCLES = `EE_LAUNCH_CYCLES;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [31:0] count_reg;
  reg  [31:0] count_next;
  reg         unlock_bit_reg;
  reg         load_bit_reg;
  reg         read_strobe_reg;
  reg  [3:0]  ctrl_rsvd_reg;
  reg  [7:0]  eeprom_data_reg;
  reg  [3:0]  row_select_reg;
  reg  [2:0]  byte_select_reg;
  reg         addr_rsvd_reg;
  reg  [2:0]  irq_stat_reg;
  reg  [2:0]  irq_mask_reg;
  reg         fetch_wait_reg;
  wire        write_in_progress;
  wire [7:0]  eeprom_byte_value;
  wire        wr_ctrl;
  wire        wr_data;
  wire        wr_addr;
  wire        load_fall;
  wire        start_prog;
  wire        drop_page;
  wire        start_read;
  wire        commit;
  wire        fetch_done;
  wire [2:0]  irq_events;

  // ********************
  // Address decode
  // ********************
  assign wr_ctrl = wr_in && (addr_in == `EE_CTRL_ADDR);
  assign wr_data = wr_in && (addr_in == `EE_DATA_ADDR);
  assign wr_addr = wr_in && (addr_in == `EE_ADDR_ADDR);

  // Load falling edge from a software control write
  assign load_fall  = wr_ctrl && load_bit_reg && !wdata_in[`EE_LOAD_BIT];
  assign start_prog = load_fall && unlock_bit_reg && wdata_in[`EE_UNLOCK_BIT]; // [RQ8] [RQ4]
  assign drop_page  = load_fall && !start_prog;                               // [RQ15]
  assign start_read = wr_ctrl && wdata_in[`EE_READ_BIT] && (state_reg == ST_IDLE)
                      && !wdata_in[`EE_LOAD_BIT] && !load_bit_reg;
  assign commit     = (state_reg == ST_PROG) && (count_next == 32'd0) && (count_reg == 32'd1);
  assign fetch_done = (state_reg == ST_FETCH) && fetch_wait_reg;
  assign write_in_progress = (state_reg == ST_PROG);                          // [RQ2]

  // ********************
  // Sequencer
  // ********************
  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_prog) begin
          state_next = ST_LAUNCH;
          count_next = LAUNCH_CYCLES;
        end else if (start_read) begin
          state_next = ST_FETCH;
        end
      end
      ST_LAUNCH: begin
        // Busy rises a few cycles after load falls
        if (count_reg <= 32'd1) begin
          state_next = ST_PROG;
          count_next = PROG_CYCLES;                                           // [RQ16]
        end else begin
          count_next = count_reg - 32'd1;
        end
      end
      ST_PROG: begin
        if (count_reg <= 32'd1) begin
          state_next = ST_IDLE;                                               // [RQ10]
          count_next = 32'd0;
        end else begin
          count_next = count_reg - 32'd1;
        end
      end
      ST_FETCH: begin
        if (fetch_wait_reg) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        count_next = 32'd0;
      end
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg      <= ST_IDLE;
      count_reg      <= 32'd0;
      fetch_wait_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      count_reg      <= count_next;
      fetch_wait_reg <= (state_reg == ST_FETCH) && !fetch_wait_reg;
    end
  end

  // ********************
  // Control register
  // ********************
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      unlock_bit_reg  <= 1'b0;
      load_bit_reg    <= 1'b0;
      read_strobe_reg <= 1'b0;
      ctrl_rsvd_reg   <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        unlock_bit_reg <= wdata_in[`EE_UNLOCK_BIT];
        load_bit_reg   <= wdata_in[`EE_LOAD_BIT];
        ctrl_rsvd_reg  <= wdata_in[7:4];                                      // [RQ1]
      end
      // Read bit reads high until the fetch lands, then clears itself
      if (start_read) begin
        read_strobe_reg <= 1'b1;
      end else if (fetch_done || (wr_ctrl && !wdata_in[`EE_READ_BIT])) begin
        read_strobe_reg <= 1'b0;                                              // [RQ12]
      end
    end
  end

  // ********************
  // Address register
  // ********************
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      row_select_reg  <= 4'h0;
      byte_select_reg <= 3'h0;
      addr_rsvd_reg   <= 1'b0;
    end else if (wr_addr) begin
      byte_select_reg <= wdata_in[2:0];                                       // [RQ14]
      addr_rsvd_reg   <= wdata_in[7];
      if (!load_bit_reg) begin
        row_select_reg <= wdata_in[6:3];                                      // [RQ5]
      end
    end
  end

  // ********************
  // Data register
  // ********************
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      eeprom_data_reg <= `EE_DATA_RST;
    end else if (fetch_done) begin
      eeprom_data_reg <= eeprom_byte_value;                                   // [RQ13] [RQ12]
    end else if (wr_data) begin
      eeprom_data_reg <= wdata_in;                                            // [RQ13]
    end
  end

  // ********************
  // Storage
  // ********************
  eeprom_array u_array (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .buf_clear_in  (drop_page || (commit && state_reg == ST_PROG && count_reg == 32'd1)),
    .buf_load_in   (wr_data && load_bit_reg && unlock_bit_reg),               // [RQ6]
    .buf_index_in  (byte_select_reg),
    .buf_data_in   (wdata_in),
    .commit_in     (commit),
    .commit_row_in (row_select_reg),
    .rd_addr_in    ({row_select_reg, byte_select_reg}),
    .rd_data_out   (eeprom_byte_value)
  );

  // ********************
  // Interrupts
  // ********************
  assign irq_events = {drop_page, fetch_done, commit};

  // Set wins over a write-one clear
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((wr_in && addr_in == `EE_IRQ_STAT_ADDR) ? wdata_in[2:0] : 3'h0))
                      | irq_events;
      if (wr_in && addr_in == `EE_IRQ_MASK_ADDR) begin
        irq_mask_reg <= wdata_in[2:0];
      end
    end
  end

  assign irq_out = |(irq_stat_reg & irq_mask_reg);

  // ********************
  // Read port
  // ********************
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `EE_CTRL_ADDR:     rdata_out <= {ctrl_rsvd_reg, write_in_progress, unlock_bit_reg,
                                         load_bit_reg, read_strobe_reg};
        `EE_DATA_ADDR:     rdata_out <= eeprom_data_reg;
        `EE_ADDR_ADDR:     rdata_out <= {addr_rsvd_reg, row_select_reg, byte_select_reg};
        `EE_IRQ_STAT_ADDR: rdata_out <= {5'h00, irq_stat_reg};
        `EE_IRQ_MASK_ADDR: rdata_out <= {5'h00, irq_mask_reg};
        default:           rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end
endmodule // eeprom_page_ctrl

/* eeprom_page_ctrl_asserts.sv */
// Checker for the EEPROM register port
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module eeprom_page_ctrl_asserts #(
  parameter [31:0] PROG_CYCLES = 32'h14
) (
  input wire       sys_clk_in,
  input wire       rst_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       rd_in,
  input wire [7:0] rdata_out,
  input wire       irq_out
);
  // ****
  // Shadows of software-visible state
  // ****
  reg  [7:0]  ctl_sh, dat_sh, adr_sh, msk_sh;
  reg         dirty;
  reg  [31:0] el, rs;
  wire        wc = wr_in && addr_in == 8'h1C;
  wire        rc = rd_in && addr_in == 8'h1C;
  // Track writes, launch age and read age
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      ctl_sh <= 8'h00;
      dat_sh <= 8'h00;
      adr_sh <= 8'h00;
      msk_sh <= 8'h00;
      dirty  <= 1'h0;
      el     <= 32'hFFFFFFFF;
      rs     <= 32'hFFFFFFFF;
    end else begin
      if (el != 32'hFFFFFFFF) el <= el + 32'h1;
      if (rs != 32'hFFFFFFFF) rs <= rs + 32'h1;
      if (wc) ctl_sh <= wdata_in;
      if (wc && ctl_sh[1] && ctl_sh[2] && !wdata_in[1] && wdata_in[2]) el <= 32'h0;
      if (wc && wdata_in[0]) begin
        rs    <= 32'h0;
        dirty <= 1'h1;
      end
      if (wr_in && addr_in == 8'h1D) begin
        dat_sh <= wdata_in;
        dirty  <= 1'h0;
      end
      if (wr_in && addr_in == 8'h1E) adr_sh <= {1'h0, ctl_sh[1] ? adr_sh[6:3] : wdata_in[6:3], wdata_in[2:0]};
      if (wr_in && addr_in == 8'h20) msk_sh <= wdata_in;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  rdata_idle_a: assert property (!rd_in |=> rdata_out == 8'h00) else $error("read data not idle");
  busy_on_a: assert property (rc && el >= 32'h8 && el <= PROG_CYCLES - 32'h4 |=> rdata_out[3])
    else $error("busy missing");
  busy_off_a: assert property (rc && el >= PROG_CYCLES + 32'hC |=> !rdata_out[3])
    else $error("busy stuck");
  read_clear_a: assert property (rc && rs >= 32'h3 |=> !rdata_out[0])
    else $error("read bit stuck");
  data_rb_a: assert property (rd_in && addr_in == 8'h1D && !dirty |=> rdata_out == dat_sh)
    else $error("data readback");
  addr_rb_a: assert property (rd_in && addr_in == 8'h1E |=> rdata_out[6:0] == adr_sh[6:0])
    else $error("address readback");
  irq_mask_a: assert property (msk_sh[2:0] == 3'h0 |-> !irq_out) else $error("masked irq");
  irq_stat_a: assert property (rd_in && addr_in == 8'h1F |=> (|(rdata_out[2:0] & msk_sh[2:0])) == $past(irq_out))
    else $error("irq level");
  cover property (wc && ctl_sh[1] && !wdata_in[1]);
  cover property (rc && el >= 32'h8 && el <= 32'h10);
  cover property (irq_out);
endmodule // eeprom_page_ctrl_asserts
bind eeprom_page_ctrl eeprom_page_ctrl_asserts #(.PROG_CYCLES(PROG_CYCLES)) i_asserts (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out));

/* sw_master.sv */
// Software-side register master of the EEPROM controller
// Assumes one clock; signals change just after rising edges
`timescale 1ns/1ps
module sw_master (
  input  wire       sys_clk_in,
  output reg  [7:0] addr_out,
  output reg  [7:0] wdata_out,
  output reg        wr_out,
  output reg        rd_out
);
  // Idle bus at time zero
  initial begin
    addr_out  = 8'h00;
    wdata_out = 8'h00;
    wr_out    = 1'h0;
    rd_out    = 1'h0;
  end
  // One-cycle write
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk_in);
      addr_out  <= a;
      wdata_out <= (a == 8'h1C) ? (d & 8'h0F) : d; // Reserved bits kept clear
      wr_out    <= 1'h1;
      @(posedge sys_clk_in);
      wr_out    <= 1'h0;
      wdata_out <= ~wdata_out;
    end
  endtask
  // One-cycle read
  task rd_reg(input [7:0] a);
    begin
      @(posedge sys_clk_in);
      addr_out <= a;
      rd_out   <= 1'h1;
      @(posedge sys_clk_in);
      rd_out   <= 1'h0;
    end
  endtask
endmodule // sw_master

/* eeprom_page_ctrl_test.sv */
// Testbench of the EEPROM page controller
// Assumes the checker is bound and PROG_CYCLES is shortened
`timescale 1ns/1ps
module eeprom_page_ctrl_test;
  localparam [31:0] PROG = 32'h14;
  reg         sys_clk_in;
  reg         rst_in;
  wire [7:0]  addr_in, wdata_in, rdata_out;
  wire        wr_in, rd_in, irq_out;
  reg  [7:0]  exp_q[$];
  reg  [7:0]  d0, d1, d2;
  reg         rd_seen;
  integer     n_fail, n_tests, i;
  sw_master i_sw_master (.sys_clk_in(sys_clk_in), .addr_out(addr_in), .wdata_out(wdata_in),
    .wr_out(wr_in), .rd_out(rd_in));
  eeprom_page_ctrl #(.PROG_CYCLES(PROG)) i_eeprom_page_ctrl (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out));
  // Clock
  initial begin
    sys_clk_in = 1'h0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      exp_q.push_back(e);
      i_sw_master.rd_reg(a);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    i_sw_master.wr_reg(a, d);
  endtask
  task ee_rd(input [7:0] a, input [7:0] e);
    begin
      wr(8'h1E, a);
      wr(8'h1C, 8'h01);
      repeat (3) @(posedge sys_clk_in);
      rd(8'h1D, e);
    end
  endtask
  task irq_is(input e);
    begin
      @(negedge sys_clk_in);
      check({7'h0, irq_out}, {7'h0, e});
    end
  endtask
  task stop_test;
    begin
      $display("Checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // Read data taken the cycle after each read strobe
  always @(posedge sys_clk_in) begin
    if (rd_seen) check(rdata_out, exp_q.pop_front());
    rd_seen <= rd_in;
  end
  // Watchdog
  initial begin
    #100000;
    n_fail = n_fail + 1;
    stop_test;
  end
  // Main sequence
  initial begin
    n_fail = 0;
    n_tests = 0;
    rd_seen = 1'h0;
    rst_in = 1'h1;
    d0 = $urandom(32'h640D);
    d0 = $urandom;
    d1 = $urandom;
    d2 = $urandom;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'h0;
    for (i = 0; i < 6; i = i + 1) rd(8'h1C + i[7:0], 8'h00);
    wr(8'h1C, 8'h04); // Unlock before writing, transmitter never enabled here
    wr(8'h1E, 8'h28);
    wr(8'h1C, 8'h06);
    wr(8'h1D, d0); // Each slot once
    wr(8'h1E, 8'h7B);
    rd(8'h1E, 8'h2B);
    wr(8'h1D, d1);
    wr(8'h1E, 8'h2A);
    wr(8'h1D, d2);
    rd(8'h1D, d2);
    wr(8'h1C, 8'h04); // Load drops, unlock held
    repeat (8) @(posedge sys_clk_in);
    rd(8'h1C, 8'h0C);
    repeat (PROG + 12) @(posedge sys_clk_in); // Wait out busy
    rd(8'h1C, 8'h04);
    wr(8'h1C, 8'h00); // Relock
    ee_rd(8'h28, d0);
    ee_rd(8'h2B, d1);
    ee_rd(8'h2A, d2);
    rd(8'h1C, 8'h00);
    rd(8'h1F, 8'h03);
    irq_is(1'h0);
    wr(8'h20, 8'h07);
    irq_is(1'h1);
    wr(8'h1F, 8'h07);
    irq_is(1'h0);
    wr(8'h1C, 8'h04);
    wr(8'h1C, 8'h06);
    wr(8'h1D, ~d0);
    wr(8'h1C, 8'h00);
    repeat (PROG + 12) @(posedge sys_clk_in);
    rd(8'h1F, 8'h04);
    ee_rd(8'h2A, d2); // Dropped slot kept old byte
    repeat (3) @(posedge sys_clk_in);
    stop_test;
  end
endmodule // eeprom_page_ctrl_test
